// ==== adq_pkg.sv ====
package adq_pkg;
   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] ADQ_OFF_CTRL_FIRST = 8'h00;  // converter_ctrl_first
   localparam logic [7:0] ADQ_OFF_CTRL_SECOND = 8'h04; // converter_ctrl_second
   localparam logic [7:0] ADQ_OFF_RESULT_LO = 8'h08;   // Result low byte
   localparam logic [7:0] ADQ_OFF_RESULT_HI = 8'h0c;   // Result high nibble
   localparam logic [7:0] ADQ_OFF_PIN_SEL = 8'h10;     // analog_pin_select_reg
   localparam logic [7:0] ADQ_OFF_INT_CTRL = 8'h14;    // Interrupt enables and flag

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int ADQ_F1_START = 7;     // Start / converter reset bit
   localparam int ADQ_F1_BUSY = 6;      // conversion_busy, read only
   localparam int ADQ_F1_POWER_OFF = 5; // converter_power_off
   localparam int ADQ_F1_CHAN_LO = 0;   // channel_select_low_3b, 3 bits
   localparam int ADQ_F2_CHAN_HI = 7;   // channel_select_high
   localparam int ADQ_F2_REF_SEL = 5;   // ref_source_select
   localparam int ADQ_F2_DIV = 0;       // conv_clock_divider, 3 bits
   localparam int ADQ_FI_GIE = 0;       // global_int_enable
   localparam int ADQ_FI_CIE = 1;       // converter_int_enable
   localparam int ADQ_FI_FLAG = 2;      // converter_int_flag

   // ***************************************************************
   // Reset values and widths
   // ***************************************************************
   localparam logic ADQ_RST_POWER_OFF = 1'b1;
   localparam logic [7:0] ADQ_RST_PIN_SEL = 8'hff;
   localparam logic [2:0] ADQ_RST_DIV = 3'h0;
   localparam int ADQ_RES_W = 12;       // Result width
   localparam int ADQ_DIV_W = 3;        // Divider code width
   localparam int ADQ_PRE_W = 6;        // Prescaler width, up to /64

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int ADQ_CLK_MHZ = 40;     // pclk rate
   localparam int ADQ_CONV_TICKS = 16;  // Converter clock periods per conversion

   typedef enum logic [1:0] {ADQ_IDLE, ADQ_CONV} adq_state_e;
endpackage

// ==== adq_conv_seq.sv ====
`timescale 1ns/100ps
module adq_conv_seq
   import adq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,                  // Freezes all state when low
   input wire logic [ADQ_DIV_W-1:0] div_code, // Converter clock code
   input wire logic run,                 // One-cycle conversion launch
   input wire logic abort,               // Holds sequencer in reset
   output logic conv_busy,               // Conversion under way
   output logic conv_tick,               // Converter clock strobe
   output logic conv_done                // Last tick of a conversion
);
   // ***************************************************************
   // Divider helper
   // ***************************************************************
   // Mask of prescaler terminal count, code 7 treated as /64
   function automatic logic [ADQ_PRE_W-1:0] div_mask(input logic [ADQ_DIV_W-1:0] c);
      logic [ADQ_DIV_W-1:0] k;
      k = (c == 3'h7) ? 3'h6 : c;
      div_mask = ADQ_PRE_W'((7'h01 << k) - 7'h01);
   endfunction

   adq_state_e state_q, state_d;          // Sequencer state
   logic [ADQ_PRE_W-1:0] pre_q;           // Prescaler
   logic [3:0] cnt_q;                     // Ticks taken
   wire logic [ADQ_PRE_W-1:0] mask_w = div_mask(div_code);
   wire logic active_w = (state_q == ADQ_CONV);
   wire logic tick_w = active_w & ce & (pre_q == mask_w);
   wire logic last_w = tick_w & (cnt_q == 4'(ADQ_CONV_TICKS - 1));

   assign conv_busy = active_w;
   assign conv_tick = tick_w;
   assign conv_done = last_w & ~abort;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ADQ_IDLE: begin
            if (run && !abort) begin
               state_d = ADQ_CONV;      // Launch
            end
         end
         ADQ_CONV: begin
            if (abort || last_w) begin
               state_d = ADQ_IDLE;      // Sixteen ticks or reset
            end
         end
         default: begin
            state_d = ADQ_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ADQ_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // Prescaler and tick counter, cleared on launch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         if (!active_w || tick_w) begin
            pre_q <= '0;
         end else begin
            pre_q <= pre_q + 1'b1;   // Derived converter clock
         end
         if (!active_w) begin
            cnt_q <= '0;
         end else if (tick_w) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   logic [10:0] cyc_q;                   // ce cycles since launch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_q <= '0;
      end else if (ce) begin
         cyc_q <= active_w ? cyc_q + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_conv_length: assert property (
      conv_done && $stable(div_code) |-> cyc_q == 11'(16 * (int'(mask_w) + 1) - 1))
      else $error("Conversion length wrong");
   chk_div8_tick: assert property (
      tick_w && div_code == 3'h3 |-> pre_q == 6'h07)
      else $error("Divide by eight tick misplaced");
endmodule

// ==== adq_ctrl.sv ====
// Function
// - Analog enable routes pin, disables others
// - Analog pin drops its pull-high
// - Analog enable overrides port direction
// - One enable bit per analog channel
// - Reference select: supply or reference pin
// - Three-bit divider sets converter clock
// - Divider code three gives clock/8
// - Power-off high keeps converter disabled
// - Power-off switches converter circuits off
// - Channel select split over two registers
// - Interrupt needs global and converter enables
// - Start low-high-low launches conversion
// - Busy high during conversion, low done
// - Sixteen converter clocks per conversion
// - Software runs freely during conversion
// - Twelve-bit result in low/high registers
// - Start held high resets, forces busy
// - Conversion end sets interrupt flag
// - Codes 0-6 divide by 1..64
`timescale 1ns/100ps
module adq_ctrl
   import adq_pkg::*;
#(
   parameter int NUM_PINS = 8,           // Shared analog pins
   parameter int ADDR_W = 8              // APB address width
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ADQ_RES_W-1:0] conv_data,   // Converter output word
   input wire logic [NUM_PINS-1:0] port_direction_reg, // 1 = input
   input wire logic [NUM_PINS-1:0] pullup_setting,     // Pull-high request
   output logic [NUM_PINS-1:0] pin_analog_route,       // Pin to input mux
   output logic [NUM_PINS-1:0] pin_digital_en,         // Other functions
   output logic [NUM_PINS-1:0] pin_dir_input,          // Effective direction
   output logic [NUM_PINS-1:0] pin_pullup_en,          // Effective pull-high
   output logic [4:0] conv_channel,      // Selected analog channel
   output logic ref_pin_select,          // 1 = reference pin, 0 = supply
   output logic conv_power_down,         // Converter circuits off
   output logic conv_reset,              // Converter held in reset
   output logic conv_clk_strobe,         // Converter clock strobe
   output logic conv_irq                 // Gated interrupt request
);
   // ***************************************************************
   // Parameter checks
   // ***************************************************************
   if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
      $error("NUM_PINS must be 1 to 8");
   end
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic start_q;                        // Start bit
   logic start_prev_q;                   // Start bit one cycle ago
   logic power_off_q;                    // converter_power_off
   logic [2:0] chan_lo_q;                // channel_select_low_3b
   logic chan_hi_q;                      // channel_select_high
   logic ref_sel_q;                      // ref_source_select
   logic [ADQ_DIV_W-1:0] div_q;          // conv_clock_divider
   logic [7:0] pin_sel_q;                // analog_pin_select_reg
   logic gie_q;                          // global_int_enable
   logic cie_q;                          // converter_int_enable
   logic flag_q;                         // converter_int_flag
   logic [ADQ_RES_W-1:0] result_q;       // Last completed result
   logic [31:0] rdata_q;                 // Captured read data
   logic rd_valid_q;                     // Read data captured
   wire logic conv_busy_w;
   wire logic conv_done_w;

   // ***************************************************************
   // APB decode
   // ***************************************************************
   wire logic [7:0] off_w = paddr[7:0];
   wire logic hi_zero_w = (paddr >> 8) == '0;
   wire logic hit_f1_w = hi_zero_w & (off_w == ADQ_OFF_CTRL_FIRST);
   wire logic hit_f2_w = hi_zero_w & (off_w == ADQ_OFF_CTRL_SECOND);
   wire logic hit_lo_w = hi_zero_w & (off_w == ADQ_OFF_RESULT_LO);
   wire logic hit_hi_w = hi_zero_w & (off_w == ADQ_OFF_RESULT_HI);
   wire logic hit_pin_w = hi_zero_w & (off_w == ADQ_OFF_PIN_SEL);
   wire logic hit_int_w = hi_zero_w & (off_w == ADQ_OFF_INT_CTRL);
   wire logic hit_w = hit_f1_w | hit_f2_w | hit_lo_w | hit_hi_w | hit_pin_w | hit_int_w;
   wire logic done_xfer_w = psel & penable & ce & rd_valid_q;
   wire logic wr_w = done_xfer_w & pwrite & hit_w;

   assign pready = done_xfer_w;
   assign pslverr = done_xfer_w & ~hit_w;
   assign prdata = rdata_q;

   // ***************************************************************
   // Status view
   // ***************************************************************
   wire logic start_fall_w = start_prev_q & ~start_q;
   wire logic run_w = start_fall_w & ~power_off_q;
   wire logic abort_w = start_q | power_off_q;
   // Launch cycle counts as busy, so a poll right after start never sees idle
   wire logic busy_w = start_q | run_w | conv_busy_w;  // Forced high by start
   wire logic [7:0] f1_view_w = {start_q, busy_w, power_off_q, 2'b00, chan_lo_q};
   wire logic [7:0] f2_view_w = {chan_hi_q, 1'b0, ref_sel_q, 2'b00, div_q};
   wire logic [7:0] int_view_w = {5'h00, flag_q, cie_q, gie_q};
   wire logic [31:0] rd_mux_w =
      hit_f1_w ? {24'h000000, f1_view_w} :
      hit_f2_w ? {24'h000000, f2_view_w} :
      hit_lo_w ? {24'h000000, result_q[7:0]} :
      hit_hi_w ? {28'h0000000, result_q[ADQ_RES_W-1:8]} :
      hit_pin_w ? {24'h000000, pin_sel_q} :
      hit_int_w ? {24'h000000, int_view_w} : 32'h00000000;

   // Read capture during setup; answer in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
         rd_valid_q <= 1'b0;
      end else if (ce) begin
         rdata_q <= rd_mux_w;
         rd_valid_q <= psel & ~done_xfer_w;
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
         power_off_q <= ADQ_RST_POWER_OFF;
         chan_lo_q <= '0;
      end else if (ce && wr_w && hit_f1_w) begin
         start_q <= pwdata[ADQ_F1_START];
         power_off_q <= pwdata[ADQ_F1_POWER_OFF];
         chan_lo_q <= pwdata[ADQ_F1_CHAN_LO +: 3];
      end
   end

   // Second control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_hi_q <= 1'b0;
         ref_sel_q <= 1'b0;
         div_q <= ADQ_RST_DIV;
      end else if (ce && wr_w && hit_f2_w) begin
         chan_hi_q <= pwdata[ADQ_F2_CHAN_HI];
         ref_sel_q <= pwdata[ADQ_F2_REF_SEL];
         div_q <= pwdata[ADQ_F2_DIV +: ADQ_DIV_W];
      end
   end

   // Pin select and interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sel_q <= ADQ_RST_PIN_SEL;
         gie_q <= 1'b0;
         cie_q <= 1'b0;
      end else if (ce && wr_w) begin
         if (hit_pin_w) begin
            pin_sel_q <= pwdata[7:0];
         end
         if (hit_int_w) begin
            gie_q <= pwdata[ADQ_FI_GIE];
            cie_q <= pwdata[ADQ_FI_CIE];
         end
      end
   end

   // Request flag: end of conversion wins over a clearing write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         if (conv_done_w) begin
            flag_q <= 1'b1;
         end else if (wr_w && hit_int_w) begin
            flag_q <= pwdata[ADQ_FI_FLAG];
         end
      end
   end

   // ***************************************************************
   // Start sequencing and result capture
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_prev_q <= 1'b0;
         result_q <= '0;
      end else if (ce) begin
         start_prev_q <= start_q;
         if (conv_done_w) begin
            result_q <= conv_data;
         end
      end
   end

   // Autonomous sequencer; bus stays free meanwhile
   adq_conv_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .div_code(div_q),
      .run(run_w),
      .abort(abort_w),
      .conv_busy(conv_busy_w),
      .conv_tick(conv_clk_strobe),
      .conv_done(conv_done_w)
   );

   // ***************************************************************
   // Pin and converter outputs
   // ***************************************************************
   wire logic [NUM_PINS-1:0] ace_w = pin_sel_q[NUM_PINS-1:0];
   assign pin_analog_route = ace_w;
   assign pin_digital_en = ~ace_w;
   assign pin_dir_input = port_direction_reg | ace_w;
   assign pin_pullup_en = pullup_setting & ~ace_w;
   assign conv_channel = {chan_hi_q, 1'b0, chan_lo_q};
   assign ref_pin_select = ref_sel_q;
   assign conv_power_down = power_off_q;
   assign conv_reset = abort_w;
   assign conv_irq = flag_q & gie_q & cie_q;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start_pulse;
      start_q ##1 !start_q;
   endsequence

   chk_start_launch: assert property (
      ce && !power_off_q ##0 s_start_pulse ##0 (ce && !power_off_q) |=> conv_busy_w)
      else $error("Start pulse did not launch");
   chk_busy_start: assert property (
      start_q && ce |-> busy_w && conv_reset ##1 !conv_busy_w)
      else $error("Held start not resetting");
   chk_flag_done: assert property (
      conv_done_w && ce |=> flag_q && !conv_busy_w)
      else $error("Done did not raise flag");
   chk_irq_gate: assert property (
      $rose(conv_irq) |-> gie_q && cie_q && flag_q)
      else $error("Interrupt without enables");
   chk_pullup_off: assert property (
      (pin_pullup_en & pin_analog_route) == '0)
      else $error("Pull-high on analog pin");
   chk_dir_override: assert property (
      (pin_analog_route & ~pin_dir_input) == '0)
      else $error("Analog pin not input");
   chk_off_idle: assert property (
      power_off_q && ce |=> !conv_busy_w && !conv_done_w)
      else $error("Conversion while powered off");
   chk_result_hold: assert property (
      !(conv_done_w && ce) |=> $stable(result_q))
      else $error("Result changed without done");
endmodule

// ==== adq_conv_model.sv ====
`timescale 1ns/100ps
module adq_conv_model
   import adq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_reset,
   input wire logic conv_power_down,
   input wire logic conv_clk_strobe,
   input wire logic [ADQ_RES_W-1:0] level,
   output logic [ADQ_RES_W-1:0] conv_data
);
   // ***************************************************************
   // Converter clock counter
   // ***************************************************************
   logic [4:0] tick_q; // Converter clocks seen

   // Counts converter clocks, cleared while held in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 5'h00;
      end else if (conv_reset) begin
         tick_q <= 5'h00;
      end else if (conv_clk_strobe) begin
         tick_q <= tick_q + 5'h01;
      end
   end

   // Word valid only on the sixteenth clock while powered, else junk
   assign conv_data = (tick_q == 5'h0f && !conv_power_down) ? level : ~level;
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb
   import adq_pkg::*;
();
   // ***************************************************************
   // Signals
   // ***************************************************************
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, route, dig_en, dir_in, pull_en;
   logic [31:0] pwdata, prdata, rdat;
   logic [11:0] conv_data, level;
   logic [4:0] chan;
   logic ref_sel, pwr_dn, cv_rst, strobe, irq, last_err;
   int err_count, total_checks, n_strobe, gap_min, gap_max, cyc, last_cyc;

   adq_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_data(conv_data), .port_direction_reg(8'h30),
      .pullup_setting(8'hff), .pin_analog_route(route), .pin_digital_en(dig_en),
      .pin_dir_input(dir_in), .pin_pullup_en(pull_en), .conv_channel(chan),
      .ref_pin_select(ref_sel), .conv_power_down(pwr_dn), .conv_reset(cv_rst),
      .conv_clk_strobe(strobe), .conv_irq(irq));

   adq_conv_model conv (.pclk(pclk), .presetn(presetn), .conv_reset(cv_rst),
      .conv_power_down(pwr_dn), .conv_clk_strobe(strobe), .level(level),
      .conv_data(conv_data));

   // ***************************************************************
   // Clock, strobe monitor, watchdog
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Counts converter strobes and their spacing, sampled mid-cycle
   always @(negedge pclk) begin
      cyc++;
      if (strobe === 1'b1) begin
         if (n_strobe > 0) begin
            gap_min = (cyc - last_cyc < gap_min) ? cyc - last_cyc : gap_min;
            gap_max = (cyc - last_cyc > gap_max) ? cyc - last_cyc : gap_max;
         end
         n_strobe++;
         last_cyc = cyc;
      end
   end

   // Cuts a hang short
   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      wrap_up();
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, held until pready is seen high at a rising edge
   // Returns mid-cycle so that outputs written at that edge have settled
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   // One full conversion at a divider code
   task automatic convert(input logic [2:0] code, input logic [11:0] lvl);
      int k;
      int g;
      level <= lvl;
      g = (code == 3'h7) ? 64 : (1 << code);
      apb(1'b1, ADQ_OFF_CTRL_SECOND, {24'h0, 5'h14, code});
      apb(1'b1, ADQ_OFF_INT_CTRL, 32'h3);
      apb(1'b1, ADQ_OFF_CTRL_FIRST, 32'h85);
      apb(1'b0, ADQ_OFF_CTRL_FIRST, 32'h0);
      chk("busy in reset", 32'h1, {31'h0, rdat[6]});
      chk("conv reset", 32'h1, {31'h0, cv_rst});
      n_strobe = 0;
      gap_min = 9999;
      gap_max = 0;
      apb(1'b1, ADQ_OFF_CTRL_FIRST, 32'h05);
      repeat (3) @(posedge pclk);
      apb(1'b0, ADQ_OFF_CTRL_FIRST, 32'h0);
      chk("busy running", 32'h1, {31'h0, rdat[6]});
      k = 0;
      do begin
         apb(1'b0, ADQ_OFF_CTRL_FIRST, 32'h0);
         k++;
      end while (rdat[6] === 1'b1 && k < 2000);
      chk("busy done", 32'h0, {31'h0, rdat[6]});
      chk("strobes", 32'd16, n_strobe);
      chk("gap min", g, gap_min);
      chk("gap max", g, gap_max);
      apb(1'b0, ADQ_OFF_RESULT_LO, 32'h0);
      chk("result low", {24'h0, lvl[7:0]}, rdat);
      apb(1'b0, ADQ_OFF_RESULT_HI, 32'h0);
      chk("result high", {28'h0, lvl[11:8]}, rdat);
      chk("irq at end", 32'h1, {31'h0, irq});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      level = 12'h000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state and pin routing
      chk("route rst", 32'hff, {24'h0, route});
      chk("pull rst", 32'h0, {24'h0, pull_en});
      chk("power rst", 32'h1, {31'h0, pwr_dn});
      apb(1'b0, ADQ_OFF_CTRL_FIRST, 32'h0);
      chk("ctrl rst", 32'h20, rdat);
      apb(1'b0, ADQ_OFF_PIN_SEL, 32'h0);
      chk("pins rst", 32'hff, rdat);
      apb(1'b1, ADQ_OFF_PIN_SEL, 32'h0f);
      chk("route", 32'h0f, {24'h0, route});
      chk("digital", 32'hf0, {24'h0, dig_en});
      chk("direction", 32'h3f, {24'h0, dir_in});
      chk("pull", 32'hf0, {24'h0, pull_en});
      // Every divider code, full scale on code 6, undefined code 7 as /64
      for (int c = 0; c < 8; c++) begin
         convert(c[2:0], (c == 6) ? 12'hfff : 12'h0a5 + 12'h111 * c[11:0]);
      end
      chk("power on", 32'h0, {31'h0, pwr_dn});
      chk("channel", 32'h15, {27'h0, chan});
      chk("ref pin", 32'h1, {31'h0, ref_sel});
      apb(1'b1, ADQ_OFF_CTRL_SECOND, 32'h03);
      chk("ref supply", 32'h0, {31'h0, ref_sel});
      chk("channel lo", 32'h05, {27'h0, chan});
      // Interrupt gating over all enable pairs
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, ADQ_OFF_INT_CTRL, 32'h4 | e);
         chk("irq gate", {31'h0, e == 3}, {31'h0, irq});
      end
      apb(1'b1, ADQ_OFF_INT_CTRL, 32'h3);
      chk("irq clear", 32'h0, {31'h0, irq});
      // Start while powered off does nothing
      apb(1'b1, ADQ_OFF_CTRL_FIRST, 32'h20);
      chk("power off", 32'h1, {31'h0, pwr_dn});
      level <= 12'h123;
      n_strobe = 0;
      apb(1'b1, ADQ_OFF_CTRL_FIRST, 32'ha0);
      apb(1'b1, ADQ_OFF_CTRL_FIRST, 32'h20);
      repeat (300) @(posedge pclk);
      chk("off strobes", 32'h0, n_strobe);
      apb(1'b0, ADQ_OFF_INT_CTRL, 32'h0);
      chk("off flag", 32'h3, rdat);
      // Read-only result and unmapped address
      apb(1'b1, ADQ_OFF_RESULT_LO, 32'h12);
      apb(1'b0, ADQ_OFF_RESULT_LO, 32'h0);
      chk("result kept", 32'h1c, rdat);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, last_err});
      chk("unmapped data", 32'h0, rdat);
      wrap_up();
   end
endmodule
